// ### include/load_exec_pkg.sv
/*
  Shared constants and carriers for the fixed-point load datapath:
  register offsets, field positions, reset values, opcodes and the
  instruction and local-store write carriers.
  Assumes a 32-bit APB register bus and a 16-entry general register file.
*/
`default_nettype none

package load_exec_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] OFF_INSTR = 8'h00;
  localparam logic [7:0] OFF_OPADDR = 8'h04;
  localparam logic [7:0] OFF_STATUS = 8'h08;
  localparam logic [7:0] OFF_INT_STATUS = 8'h0c;
  localparam logic [7:0] OFF_INT_MASK = 8'h10;
  localparam logic [7:0] OFF_GPR_BASE = 8'h40;
  localparam logic [7:0] OFF_GPR_LAST = 8'h7c;
  localparam int unsigned GPR_COUNT = 16;
  localparam int unsigned DATA_W = 32;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int unsigned ST_BUSY = 0;
  localparam int unsigned ST_CC_LSB = 1;
  localparam int unsigned ST_ZERO = 3;
  localparam int unsigned ST_OVF = 4;
  localparam int unsigned EV_DONE = 0;
  localparam int unsigned EV_SPEC = 1;
  localparam int unsigned EV_INVALID = 2;
  localparam int unsigned EV_W = 3;
  localparam int unsigned OPADDR_W = 24;
  // Address bits 21, 22 and 23 counted from the left of 24 bits
  localparam int unsigned WORD_SEL_BIT = 2;
  localparam int unsigned HALF_SEL_BIT = 1;
  localparam int unsigned BYTE_SEL_BIT = 0;

  // ----------------------------------------------------------------
  // Reset values and constants
  // ----------------------------------------------------------------
  localparam logic [1:0] CC_RESET = 2'h0;
  localparam logic [EV_W-1:0] INT_MASK_RESET = 3'h0;
  localparam logic [23:0] OPADDR_RESET = 24'h00_0000;
  localparam logic [31:0] MASK_SEED = 32'hffff_fff0;
  localparam int unsigned MASK_SHIFT = 4;
  localparam logic [31:0] MAX_NEG = 32'h8000_0000;
  localparam logic [1:0] CC_ZERO = 2'h0;
  localparam logic [1:0] CC_NEG = 2'h1;
  localparam logic [1:0] CC_POS = 2'h2;
  localparam logic [1:0] CC_OVF = 2'h3;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_REG_TO_REG_LOAD = 8'h18;
  localparam logic [7:0] OP_WORD_LOAD = 8'h58;
  localparam logic [7:0] OP_HALFWORD_LOAD = 8'h48;
  localparam logic [7:0] OP_LOAD_AND_TEST = 8'h12;
  localparam logic [7:0] OP_LOAD_COMPLEMENT = 8'h13;

  typedef struct packed {
    logic [7:0] opcode;
    logic [3:0] first_reg_field;
    logic [3:0] second_reg_field;
  } instr_t;

  typedef struct packed {
    logic en;
    logic [3:0] addr;
    logic [31:0] data;
  } ls_wr_t;

endpackage

`default_nettype wire

// ### hw/gpr_store.sv
/*
  General register local store: one write port, one read port whose
  data come out of a register one cycle after the address.
  Assumes the single user never reads and writes the same entry in
  one cycle when it needs the new value.
*/
`timescale 1ns/1ps
`default_nettype none

module gpr_store #(
  parameter int unsigned WIDTH = 32,
  parameter int unsigned DEPTH = 16,
  parameter int unsigned AW = 4
) (
  input wire logic pclk,
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  if (DEPTH < 2 || DEPTH > (1 << AW))
  begin : g_bad_depth
    $error("gpr_store: depth does not fit the address width");
  end

  always_ff @(posedge pclk)
  begin
    if (wr_en)
    begin
      mem[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge pclk)
  begin
    rd_data <= mem[rd_addr];
  end

endmodule

`default_nettype wire

// ### hw/fixed_point_load_exec.sv
/*
  Execution datapath for the fixed-point load group: register copy,
  word load, halfword load with sign extension, load-and-test and
  load-complement, with condition code, behind an APB slave.
  Assumes the storage request for the operand doubleword was issued
  before the instruction is written, and that storage data arrive on
  the same clock, marked by storage_data_valid.
*/
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ps
`default_nettype none

module fixed_point_load_exec (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic [1:0] condition_code,
  input wire logic [63:0] storage_data_bus_out,
  input wire logic storage_data_valid
);
  import load_exec_pkg::*;

  typedef enum logic [3:0] {
    S_IDLE, S_READ_R2, S_LOAD_T, S_SPEC, S_MASK1, S_MASK2, S_MASK3,
    S_WAIT_DATA, S_EXEC, S_WRITE, S_END_OP
  } state_t;

  state_t state;
  instr_t instr;
  logic [OPADDR_W-1:0] opaddr;
  logic [31:0] work;
  logic [31:0] mask;
  logic zero_flag;
  logic ovf_flag;
  logic [EV_W-1:0] int_status;
  logic [EV_W-1:0] int_mask;
  logic [EV_W-1:0] ev_set;
  logic [31:0] adder_input_a;
  logic [31:0] adder_input_b;
  logic carry_in;
  logic [32:0] sum_full;
  logic [31:0] adder_output;
  logic [15:0] half;
  logic complement_ovf;
  logic misaligned;
  logic [31:0] sel_word;
  ls_wr_t ls_wr;
  logic [3:0] ls_rd_addr;
  logic [31:0] ls_rd_data;
  logic busy;
  logic apb_done;
  logic start;
  logic hit_gpr;
  logic [31:0] rd_value;
  logic rd_err;

  assign busy = (state != S_IDLE);

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  // One wait state on every access so local store reads can land.
  // Refusal is decided in the wait state; busy may drop before the
  // commit edge, so an access refused there must never take effect.
  assign apb_done = psel && penable && pready && !pslverr;
  assign hit_gpr = (paddr >= OFF_GPR_BASE) && (paddr <= OFF_GPR_LAST);
  assign start = apb_done && pwrite && (paddr == OFF_INSTR) && !busy;

  always_comb
  begin
    rd_value = 32'h0000_0000;
    rd_err = 1'b0;
    if (paddr[1:0] != 2'h0)
    begin
      rd_err = 1'b1;
    end
    else if (paddr == OFF_INSTR)
    begin
      rd_value[15:0] = instr;
      rd_err = pwrite && busy;
    end
    else if (paddr == OFF_OPADDR)
    begin
      rd_value[OPADDR_W-1:0] = opaddr;
      rd_err = pwrite && busy;
    end
    else if (paddr == OFF_STATUS)
    begin
      rd_value[ST_BUSY] = busy;
      rd_value[ST_CC_LSB +: 2] = condition_code;
      rd_value[ST_ZERO] = zero_flag;
      rd_value[ST_OVF] = ovf_flag;
    end
    else if (paddr == OFF_INT_STATUS)
    begin
      rd_value[EV_W-1:0] = int_status;
    end
    else if (paddr == OFF_INT_MASK)
    begin
      rd_value[EV_W-1:0] = int_mask;
    end
    else if (hit_gpr)
    begin
      // Local store port belongs to the datapath while busy
      rd_value = ls_rd_data;
      rd_err = busy;
    end
    else
    begin
      rd_err = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      pready <= 1'b0;
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && rd_err;
      if (psel && penable && !pready && !pwrite)
      begin
        prdata <= rd_value;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      instr <= '0;
      opaddr <= OPADDR_RESET;
      int_mask <= INT_MASK_RESET;
    end
    else if (apb_done && pwrite && !busy)
    begin
      if (paddr == OFF_INSTR)
      begin
        instr <= instr_t'(pwdata[15:0]);
      end
      else if (paddr == OFF_OPADDR)
      begin
        opaddr <= pwdata[OPADDR_W-1:0];
      end
      else if (paddr == OFF_INT_MASK)
      begin
        int_mask <= pwdata[EV_W-1:0];
      end
    end
    else if (apb_done && pwrite && paddr == OFF_INT_MASK)
    begin
      int_mask <= pwdata[EV_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // Interrupt status
  // ----------------------------------------------------------------
  always_comb
  begin
    ev_set = '0;
    ev_set[EV_DONE] = (state == S_END_OP);
    ev_set[EV_SPEC] = (state == S_SPEC) && misaligned;
    ev_set[EV_INVALID] = (state == S_END_OP) && !(
      instr.opcode == OP_REG_TO_REG_LOAD || instr.opcode == OP_WORD_LOAD ||
      instr.opcode == OP_HALFWORD_LOAD || instr.opcode == OP_LOAD_AND_TEST ||
      instr.opcode == OP_LOAD_COMPLEMENT);
  end

  // Set beats a write-one clear landing in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      int_status <= '0;
      irq <= 1'b0;
    end
    else
    begin
      if (apb_done && pwrite && paddr == OFF_INT_STATUS)
      begin
        int_status <= (int_status & ~pwdata[EV_W-1:0]) | ev_set;
      end
      else
      begin
        int_status <= int_status | ev_set;
      end
      irq <= |(int_status & int_mask);
    end
  end

  // ----------------------------------------------------------------
  // Local store
  // ----------------------------------------------------------------
  // Only the first register is ever written by an instruction
  always_comb
  begin
    ls_wr = '0;
    if (state == S_WRITE)
    begin
      ls_wr.en = 1'b1;
      ls_wr.addr = instr.first_reg_field;
      ls_wr.data = work;
    end
    else if (apb_done && pwrite && hit_gpr && !busy)
    begin
      ls_wr.en = 1'b1;
      ls_wr.addr = paddr[5:2];
      ls_wr.data = pwdata;
    end
  end

  assign ls_rd_addr = (state == S_READ_R2) ? instr.second_reg_field
                                           : paddr[5:2];

  gpr_store #(
    .WIDTH(DATA_W),
    .DEPTH(GPR_COUNT),
    .AW(4)
  ) i_gpr_store (
    .pclk(pclk),
    .wr_en(ls_wr.en),
    .wr_addr(ls_wr.addr),
    .wr_data(ls_wr.data),
    .rd_addr(ls_rd_addr),
    .rd_data(ls_rd_data)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  assign misaligned = opaddr[BYTE_SEL_BIT] ||
    (instr.opcode == OP_WORD_LOAD && opaddr[HALF_SEL_BIT]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= S_IDLE;
    end
    else
    begin
      case (state)
        S_IDLE:
          if (start)
          begin
            case (pwdata[15:8])
              OP_REG_TO_REG_LOAD, OP_LOAD_AND_TEST, OP_LOAD_COMPLEMENT:
                state <= S_READ_R2;
              OP_WORD_LOAD, OP_HALFWORD_LOAD:
                state <= S_SPEC;
              default:
                state <= S_END_OP;
            endcase
          end
        S_READ_R2:
          state <= S_LOAD_T;
        S_LOAD_T:
          state <= S_EXEC;
        S_SPEC:
          if (misaligned)
          begin
            state <= S_END_OP;
          end
          else if (instr.opcode == OP_HALFWORD_LOAD)
          begin
            state <= S_MASK1;
          end
          else
          begin
            state <= S_WAIT_DATA;
          end
        S_MASK1:
          state <= S_MASK2;
        S_MASK2:
          state <= S_MASK3;
        S_MASK3:
          state <= S_WAIT_DATA;
        // Doubleword was requested during fetch; just wait for it
        S_WAIT_DATA:
          if (storage_data_valid)
          begin
            state <= S_EXEC;
          end
        S_EXEC:
          state <= S_WRITE;
        S_WRITE:
          state <= S_END_OP;
        S_END_OP:
          state <= S_IDLE;
        default:
          state <= S_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Mask and adder
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mask <= 32'h0000_0000;
    end
    else if (state == S_MASK1)
    begin
      mask <= MASK_SEED << MASK_SHIFT;
    end
    else if (state == S_MASK2 || state == S_MASK3)
    begin
      mask <= mask << MASK_SHIFT;
    end
  end

  assign sel_word = opaddr[WORD_SEL_BIT] ? storage_data_bus_out[31:0]
                                         : storage_data_bus_out[63:32];
  assign half = opaddr[HALF_SEL_BIT] ? work[15:0] : work[31:16];
  assign complement_ovf = (work == MAX_NEG);

  always_comb
  begin
    adder_input_a = work;
    adder_input_b = 32'h0000_0000;
    carry_in = 1'b0;
    if (instr.opcode == OP_HALFWORD_LOAD)
    begin
      // Carry out of bit 16 cancels the mask for a positive half
      adder_input_a = {15'h0000, ~half[15], half};
      adder_input_b = mask;
    end
    else if (instr.opcode == OP_LOAD_COMPLEMENT)
    begin
      adder_input_a = ~work;
      carry_in = 1'b1;
    end
  end

  assign sum_full = {1'b0, adder_input_a} + {1'b0, adder_input_b} +
                    {32'h0000_0000, carry_in};
  assign adder_output = sum_full[31:0];

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      work <= 32'h0000_0000;
    end
    else if (state == S_LOAD_T)
    begin
      work <= ls_rd_data;
    end
    else if (state == S_WAIT_DATA && storage_data_valid)
    begin
      work <= sel_word;
    end
    else if (state == S_EXEC)
    begin
      work <= adder_output;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      zero_flag <= 1'b0;
      ovf_flag <= 1'b0;
      condition_code <= CC_RESET;
    end
    else if (state == S_EXEC && (instr.opcode == OP_LOAD_AND_TEST ||
             instr.opcode == OP_LOAD_COMPLEMENT))
    begin
      zero_flag <= (adder_output == 32'h0000_0000);
      ovf_flag <= (instr.opcode == OP_LOAD_COMPLEMENT) && complement_ovf;
      if (instr.opcode == OP_LOAD_COMPLEMENT && complement_ovf)
      begin
        condition_code <= CC_OVF;
      end
      else if (adder_output == 32'h0000_0000)
      begin
        condition_code <= CC_ZERO;
      end
      else if (adder_output[31])
      begin
        condition_code <= CC_NEG;
      end
      else
      begin
        condition_code <= CC_POS;
      end
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_mask_steps;
    mask == 32'hffff_ff00 ##1 mask == 32'hffff_f000 ##1
    mask == 32'hffff_0000;
  endsequence

  a_rr_no_check: assert property (
    state == S_READ_R2 |=> state == S_LOAD_T ##1 state == S_EXEC
    ##1 state == S_WRITE ##1 state == S_END_OP)
    else $error("register copy sequence broken");

  a_spec_suppress: assert property (
    state == S_SPEC && misaligned |=> state == S_END_OP &&
    int_status[EV_SPEC] ##1 state == S_IDLE)
    else $error("specification fault not suppressed");

  a_word_select: assert property (
    state == S_WAIT_DATA && storage_data_valid |=>
    work == (opaddr[WORD_SEL_BIT] ? $past(storage_data_bus_out[31:0])
                                  : $past(storage_data_bus_out[63:32])))
    else $error("wrong word of doubleword taken");

  a_mask_build: assert property (
    state == S_MASK1 |=> s_mask_steps)
    else $error("sign mask not built as expected");

  a_half_extend: assert property (
    state == S_EXEC && instr.opcode == OP_HALFWORD_LOAD |=>
    work == {{16{$past(half[15])}}, $past(half)})
    else $error("halfword not sign extended");

  a_zero_detect: assert property (
    state == S_EXEC && instr.opcode == OP_LOAD_AND_TEST |=>
    zero_flag == ($past(work) == 32'h0000_0000))
    else $error("zero flag wrong after load and test");

  a_test_code: assert property (
    state == S_EXEC && instr.opcode == OP_LOAD_AND_TEST |=>
    condition_code == (zero_flag ? CC_ZERO : (work[31] ? CC_NEG : CC_POS)))
    else $error("load and test condition code wrong");

  a_complement_ovf: assert property (
    state == S_EXEC && instr.opcode == OP_LOAD_COMPLEMENT &&
    work == MAX_NEG |=> ovf_flag && condition_code == CC_OVF)
    else $error("complement overflow not flagged");

  a_complement_val: assert property (
    state == S_EXEC && instr.opcode == OP_LOAD_COMPLEMENT |=>
    work == 32'(~$past(work) + 32'h0000_0001))
    else $error("complement result wrong");

  a_write_first: assert property (
    state == S_WRITE |-> ls_wr.en && ls_wr.addr == instr.first_reg_field
    && ls_wr.data == work)
    else $error("result not written to first register");

endmodule

`default_nettype wire

// ### verification/storage_model.sv
/*
  Storage-side partner: presents the operand doubleword on the storage
  data bus, with its valid flag, a chosen number of cycles after the
  bench arms it.
  Assumes one clock shared with the datapath.
*/
`timescale 1ns/1ps
`default_nettype none

module storage_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic armed,
  input wire logic [63:0] dword,
  input wire logic [3:0] lag,
  output logic [63:0] storage_data_bus_out,
  output logic storage_data_valid
);
  logic [3:0] cnt;

  // ------------------------------------------------------------
  // Data delivery
  // ------------------------------------------------------------
  // Idle bus inverts every cycle so stale data never looks valid
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt <= 4'h0;
      storage_data_valid <= 1'b0;
      storage_data_bus_out <= 64'h0;
    end
    else if (!armed || cnt < lag)
    begin
      cnt <= armed ? cnt + 4'h1 : 4'h0;
      storage_data_valid <= 1'b0;
      storage_data_bus_out <= ~storage_data_bus_out;
    end
    else
    begin
      storage_data_valid <= 1'b1;
      storage_data_bus_out <= dword;
    end
  end
endmodule

`default_nettype wire

// ### verification/fixed_point_load_exec_tb.sv
/*
  Self-checking bench for the fixed-point load datapath, driven over
  APB, with the storage partner on the doubleword bus.
  Assumes the package and the storage model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module fixed_point_load_exec_tb;
  import load_exec_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic svalid, armed, err;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] condition_code;
  logic [63:0] sbus, dword;
  logic [15:0] h;
  logic [3:0] lag;
  int error_cnt, tests_run;

  fixed_point_load_exec i_fixed_point_load_exec (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq),
    .condition_code(condition_code), .storage_data_bus_out(sbus),
    .storage_data_valid(svalid)
  );

  storage_model i_storage_model (
    .pclk(pclk), .presetn(presetn), .armed(armed), .dword(dword),
    .lag(lag), .storage_data_bus_out(sbus), .storage_data_valid(svalid)
  );

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ------------------------------------------------------------
  // Bus and compare tasks
  // ------------------------------------------------------------
  task automatic end_sim();
    if (error_cnt == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until pready is sampled high or 20 cycles pass, then released
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge pclk);
      n++;
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
    begin
      error_cnt++;
      end_sim();
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    check(rd, exp);
  endtask

  function automatic logic [7:0] gpr(input int n);
    return OFF_GPR_BASE + 8'(4 * n);
  endfunction

  // Start an instruction, optionally poke it while busy, wait for idle
  task automatic run(input logic [7:0] op, input logic [3:0] r1,
                     input logic [3:0] r2, input logic poke);
    int n;
    instr_t ins;
    ins = '{op, r1, r2};
    n = 0;
    @(posedge pclk);
    armed <= 1'b1;
    wr(OFF_INSTR, {16'h0, ins});
    if (poke)
    begin
      wr(OFF_INSTR, 32'h0);
      check(32'(err), 32'h1);
      apb(1'b0, gpr(r2), 32'h0);
      check(32'(err), 32'h1);
    end
    rd = 32'h1;
    while (rd[ST_BUSY] !== 1'b0 && n < 40)
    begin
      apb(1'b0, OFF_STATUS, 32'h0);
      n++;
    end
    armed <= 1'b0;
    if (n >= 40)
    begin
      error_cnt++;
      end_sim();
    end
  endtask

  task automatic rr(input logic [7:0] op, input logic [31:0] v,
                    input logic [31:0] e, input logic [1:0] cc);
    wr(gpr(5), v);
    run(op, 4'h6, 4'h5, 1'b0);
    rdchk(gpr(6), e);
    rdchk(gpr(5), v);
    check(32'(condition_code), 32'(cc));
    rdchk(OFF_STATUS, {27'h0, cc == CC_OVF, cc == CC_ZERO, cc, 1'b0});
  endtask

  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    armed = 1'b0;
    dword = 64'h0;
    lag = 4'h0;
    error_cnt = 0;
    tests_run = 0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    check(32'(condition_code), 32'h0);
    check(32'(irq), 32'h0);
    rdchk(OFF_STATUS, 32'h0);
    rdchk(OFF_INT_MASK, 32'h0);
    rdchk(OFF_OPADDR, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    check(32'(err), 32'h1);
    apb(1'b0, 8'h02, 32'h0);
    check(32'(err), 32'h1);
    for (int i = 0; i < 16; i++)
      wr(gpr(i), 32'h1010_1010 * 32'(i));
    rr(OP_LOAD_AND_TEST, 32'h0, 32'h0, CC_ZERO);
    rr(OP_LOAD_AND_TEST, 32'h8000_0001, 32'h8000_0001, CC_NEG);
    rr(OP_LOAD_AND_TEST, 32'h7fff_ffff, 32'h7fff_ffff, CC_POS);
    rr(OP_LOAD_COMPLEMENT, 32'h5, 32'hffff_fffb, CC_NEG);
    rr(OP_LOAD_COMPLEMENT, 32'hffff_fff9, 32'h7, CC_POS);
    rr(OP_LOAD_COMPLEMENT, 32'h0, 32'h0, CC_ZERO);
    rr(OP_LOAD_COMPLEMENT, MAX_NEG, MAX_NEG, CC_OVF);
    // Copy leaves the code alone
    wr(OFF_INT_STATUS, 32'h7);
    run(OP_REG_TO_REG_LOAD, 4'h3, 4'h9, 1'b0);
    rdchk(gpr(3), 32'h9090_9090);
    rdchk(gpr(9), 32'h9090_9090);
    check(32'(condition_code), 32'(CC_OVF));
    rdchk(OFF_INT_STATUS, 32'h1);
    check(32'(irq), 32'h0);
    run(OP_LOAD_AND_TEST, 4'h7, 4'h7, 1'b0);
    rdchk(gpr(7), 32'h7070_7070);
    check(32'(condition_code), 32'(CC_POS));
    // Prompt and slow storage answers; the slow one is poked while busy
    dword <= 64'h8765_4321_0fed_cba9;
    for (int i = 0; i < 2; i++)
    begin
      lag <= 4'(9 * i);
      wr(OFF_OPADDR, 32'(i * 4));
      run(OP_WORD_LOAD, 4'h8, 4'h0, 1'(i));
      rdchk(gpr(8), i ? dword[31:0] : dword[63:32]);
    end
    dword <= 64'h8001_7ffe_f00d_1234;
    for (int i = 0; i < 4; i++)
    begin
      lag <= 4'(3 * i);
      wr(OFF_OPADDR, 32'(i * 2));
      h = dword[63 - 16 * i -: 16];
      run(OP_HALFWORD_LOAD, 4'(10 + i), 4'h0, 1'b0);
      rdchk(gpr(10 + i), {{16{h[15]}}, h});
    end
    // Misaligned word and halfword operands are suppressed before the data arrive
    wr(OFF_INT_STATUS, 32'h7);
    wr(OFF_OPADDR, 32'h2);
    run(OP_WORD_LOAD, 4'h8, 4'h0, 1'b0);
    rdchk(gpr(8), 32'h0fed_cba9);
    rdchk(OFF_INT_STATUS, 32'h3);
    wr(OFF_INT_STATUS, 32'h7);
    wr(OFF_OPADDR, 32'h1);
    run(OP_HALFWORD_LOAD, 4'h8, 4'h0, 1'b0);
    rdchk(gpr(8), 32'h0fed_cba9);
    rdchk(OFF_INT_STATUS, 32'h3);
    wr(OFF_INT_STATUS, 32'h7);
    run(8'h00, 4'h8, 4'h0, 1'b0);
    rdchk(OFF_INT_STATUS, 32'h5);
    // Interrupt raised by unmasking, dropped by clearing
    wr(OFF_INT_MASK, 32'h1);
    rdchk(OFF_INT_MASK, 32'h1);
    check(32'(irq), 32'h1);
    wr(OFF_INT_MASK, 32'h2);
    rdchk(OFF_INT_STATUS, 32'h5);
    check(32'(irq), 32'h0);
    wr(OFF_INT_MASK, 32'h4);
    rdchk(OFF_INT_MASK, 32'h4);
    check(32'(irq), 32'h1);
    wr(OFF_INT_STATUS, 32'h7);
    rdchk(OFF_INT_STATUS, 32'h0);
    check(32'(irq), 32'h0);
    end_sim();
  end
endmodule

`default_nettype wire
